// file: design/cmd_src_pkg.sv
// package: constants and types for the command source selector
package cmd_src_pkg;

  // ************************************************************
  // register map (byte addresses)
  // ************************************************************
  localparam logic [3:0] ADDR_MODE    = 4'h0;
  localparam logic [3:0] ADDR_STATUS  = 4'h4;
  localparam logic [3:0] ADDR_REMOTE  = 4'h8;

  // ************************************************************
  // field layout of the mode register
  // ************************************************************
  localparam int SERIAL_LSB = 0;
  localparam int SERIAL_W   = 4;
  localparam int BUS_LSB    = 8;
  localparam int BUS_W      = 2;
  localparam int PERMIT_ASSIGNED_BIT = 16;
  localparam int LOCAL_FREQ_SEL_LSB  = 20;
  localparam int LOCAL_FREQ_SEL_W    = 4;
  localparam int LOCAL_RUN_SEL_BIT   = 24;

  // ************************************************************
  // field layout of the status register
  // ************************************************************
  localparam int FREQ_SRC_LSB = 0;
  localparam int RUN_SRC_LSB  = 4;
  localparam int PERMIT_BIT   = 8;
  localparam int SRC_W        = 2;

  // ************************************************************
  // remote run register: forward, backward, seven general inputs
  // ************************************************************
  localparam int RUN_W = 9;

  localparam logic [3:0] SERIAL_MAX = 4'h8;

  // reset values
  localparam logic [3:0] SERIAL_RESET = 4'h0;
  localparam logic [1:0] BUS_RESET    = 2'h0;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    SRC_LOCAL,
    SRC_PORT1,
    SRC_PORT2,
    SRC_FIELDBUS
  } src_t;

endpackage : cmd_src_pkg

// file: design/source_mux.sv
// module: picks one command word from four sources
`timescale 1ns/10ps
module source_mux
  import cmd_src_pkg::*;
#(
  parameter int W = 16
) (
  input  wire logic [1:0]   sel,
  input  wire logic [W-1:0] local_in,
  input  wire logic [W-1:0] port1_in,
  input  wire logic [W-1:0] port2_in,
  input  wire logic [W-1:0] bus_in,
  output logic      [W-1:0] out
);

  // only the selected source passes, the others are dropped
  always_comb begin
    case (src_t'(sel))
      SRC_LOCAL: out = local_in;
      SRC_PORT1: out = port1_in;
      SRC_PORT2: out = port2_in;
      default:   out = bus_in;
    endcase
  end

endmodule : source_mux

// file: design/command_source_selector.sv
// module: frequency and run command source selector with axi4-lite regs
//
// Implementation choices: the AXI4-Lite register port and the register offsets.
`timescale 1ns/10ps
module command_source_selector
  import cmd_src_pkg::*;
#(
  parameter int FREQ_W = 16
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [3:0]        s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [3:0]        s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              remote_cmd_permit,
  input  wire logic [FREQ_W-1:0] freq_selected_setting,
  input  wire logic [FREQ_W-1:0] freq_multistep,
  input  wire logic              multistep_active,
  input  wire logic [RUN_W-1:0]  keypad_run,
  input  wire logic [RUN_W-1:0]  terminal_run,
  input  wire logic [FREQ_W-1:0] port1_freq,
  input  wire logic [RUN_W-1:0]  port1_run,
  input  wire logic [FREQ_W-1:0] port2_freq,
  input  wire logic [RUN_W-1:0]  port2_run,
  input  wire logic [FREQ_W-1:0] fieldbus_freq,
  input  wire logic [RUN_W-1:0]  fieldbus_run,
  output logic [FREQ_W-1:0]      freq_command,
  output logic [RUN_W-1:0]       run_command,
  output logic [1:0]             freq_source,
  output logic [1:0]             run_source
);

  // ************************************************************
  // pin synchronisers
  // ************************************************************
  logic       permit_meta;
  logic       permit_sync;
  logic [RUN_W-1:0] term_meta;
  logic [RUN_W-1:0] term_sync;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      permit_meta <= 1'b0;
      permit_sync <= 1'b0;
      term_meta   <= '0;
      term_sync   <= '0;
    end else begin
      permit_meta <= remote_cmd_permit;
      permit_sync <= permit_meta;
      term_meta   <= terminal_run;
      term_sync   <= term_meta;
    end
  end

  // ************************************************************
  // configuration registers
  // ************************************************************
  logic [SERIAL_W-1:0] serial_link_source_mode;
  logic [BUS_W-1:0]    fieldbus_source_mode;
  logic                permit_assigned;
  logic [LOCAL_FREQ_SEL_W-1:0] local_frequency_selection;
  logic                local_run_selection;
  logic [RUN_W-1:0]    remote_run_word;

  // ************************************************************
  // axi4-lite write channel
  // ************************************************************
  logic       aw_held;
  logic       w_held;
  logic [3:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        do_write;
  logic        write_ok;

  assign do_write = aw_held && w_held && !s_axi_bvalid;
  assign write_ok = (aw_addr == ADDR_MODE) || (aw_addr == ADDR_REMOTE);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_addr       <= '0;
      w_data        <= '0;
      w_strb        <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !w_held && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= write_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // register storage; out-of-range serial codes are kept as written
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      serial_link_source_mode   <= SERIAL_RESET;
      fieldbus_source_mode      <= BUS_RESET;
      permit_assigned           <= 1'b0;
      local_frequency_selection <= '0;
      local_run_selection       <= 1'b0;
      remote_run_word           <= '0;
    end else if (do_write && aw_addr == ADDR_MODE) begin
      if (w_strb[0]) begin
        serial_link_source_mode <= w_data[SERIAL_LSB +: SERIAL_W];
      end
      if (w_strb[1]) begin
        fieldbus_source_mode <= w_data[BUS_LSB +: BUS_W];
      end
      if (w_strb[2]) begin
        permit_assigned           <= w_data[PERMIT_ASSIGNED_BIT];
        local_frequency_selection <=
          w_data[LOCAL_FREQ_SEL_LSB +: LOCAL_FREQ_SEL_W];
      end
      if (w_strb[3]) begin
        local_run_selection <= w_data[LOCAL_RUN_SEL_BIT];
      end
    end else if (do_write && aw_addr == ADDR_REMOTE) begin
      if (w_strb[0]) begin
        remote_run_word[7:0] <= w_data[7:0];
      end
      if (w_strb[1]) begin
        remote_run_word[RUN_W-1] <= w_data[RUN_W-1];
      end
    end
  end

  // ************************************************************
  // source decode
  // ************************************************************
  logic       honour_modes;
  src_t       serial_freq;
  src_t       serial_run;
  src_t       next_freq_src;
  src_t       next_run_src;

  assign honour_modes = !permit_assigned || permit_sync;

  always_comb begin
    case (serial_link_source_mode)
      4'h0: begin serial_freq = SRC_LOCAL; serial_run = SRC_LOCAL; end
      4'h1: begin serial_freq = SRC_PORT1; serial_run = SRC_LOCAL; end
      4'h2: begin serial_freq = SRC_LOCAL; serial_run = SRC_PORT1; end
      4'h3: begin serial_freq = SRC_PORT1; serial_run = SRC_PORT1; end
      4'h4: begin serial_freq = SRC_PORT2; serial_run = SRC_LOCAL; end
      4'h5: begin serial_freq = SRC_PORT2; serial_run = SRC_PORT1; end
      4'h6: begin serial_freq = SRC_LOCAL; serial_run = SRC_PORT2; end
      4'h7: begin serial_freq = SRC_PORT1; serial_run = SRC_PORT2; end
      4'h8: begin serial_freq = SRC_PORT2; serial_run = SRC_PORT2; end
      default: begin serial_freq = SRC_LOCAL; serial_run = SRC_LOCAL; end
    endcase
    next_freq_src = fieldbus_source_mode[0] ? SRC_FIELDBUS
                                            : serial_freq;
    next_run_src  = fieldbus_source_mode[1] ? SRC_FIELDBUS
                                            : serial_run;
    if (!honour_modes) begin
      next_freq_src = SRC_LOCAL;
      next_run_src  = SRC_LOCAL;
    end
  end

  // ************************************************************
  // local sources and selection
  // ************************************************************
  logic [FREQ_W-1:0] local_freq;
  logic [RUN_W-1:0]  local_run;
  logic [FREQ_W-1:0] next_freq_command;
  logic [RUN_W-1:0]  next_run_command;

  assign local_freq = multistep_active ? freq_multistep
                                       : freq_selected_setting;
  assign local_run  = local_run_selection ? term_sync : keypad_run;

  source_mux #(.W(FREQ_W)) freq_mux (
    .sel      (next_freq_src),
    .local_in (local_freq),
    .port1_in (port1_freq),
    .port2_in (port2_freq),
    .bus_in   (fieldbus_freq),
    .out      (next_freq_command)
  );

  // whole nine-bit run word from one source only
  source_mux #(.W(RUN_W)) run_mux (
    .sel      (next_run_src),
    .local_in (local_run),
    .port1_in (port1_run),
    .port2_in (port2_run),
    .bus_in   (fieldbus_run),
    .out      (next_run_command)
  );

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      freq_command <= '0;
      run_command  <= '0;
      freq_source  <= SRC_LOCAL;
      run_source   <= SRC_LOCAL;
    end else begin
      freq_command <= next_freq_command;
      run_command  <= next_run_command;
      freq_source  <= next_freq_src;
      run_source   <= next_run_src;
    end
  end

  // ************************************************************
  // axi4-lite read channel
  // ************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= RESP_OKAY;
        s_axi_rdata  <= '0;
        case (s_axi_araddr)
          ADDR_MODE: begin
            s_axi_rdata[SERIAL_LSB +: SERIAL_W] <= serial_link_source_mode;
            s_axi_rdata[BUS_LSB +: BUS_W]       <= fieldbus_source_mode;
            s_axi_rdata[PERMIT_ASSIGNED_BIT]    <= permit_assigned;
            s_axi_rdata[LOCAL_FREQ_SEL_LSB +: LOCAL_FREQ_SEL_W] <=
              local_frequency_selection;
            s_axi_rdata[LOCAL_RUN_SEL_BIT]      <= local_run_selection;
          end
          ADDR_STATUS: begin
            s_axi_rdata[FREQ_SRC_LSB +: SRC_W] <= freq_source;
            s_axi_rdata[RUN_SRC_LSB +: SRC_W]  <= run_source;
            s_axi_rdata[PERMIT_BIT]            <= permit_sync;
          end
          ADDR_REMOTE: begin
            s_axi_rdata[RUN_W-1:0] <= remote_run_word;
          end
          default: begin
            s_axi_rresp <= RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule : command_source_selector

// file: tb/cmd_src_checker_assertions.sv
// checker: concurrent assertions on the selector ports
`timescale 1ns/10ps
module cmd_src_checker
  import cmd_src_pkg::*;
#(
  parameter int FREQ_W = 16
) (
  input wire logic              aclk,
  input wire logic              aresetn,
  input wire logic              s_axi_bvalid,
  input wire logic              s_axi_bready,
  input wire logic              s_axi_rvalid,
  input wire logic              s_axi_rready,
  input wire logic [FREQ_W-1:0] freq_selected_setting,
  input wire logic [FREQ_W-1:0] freq_multistep,
  input wire logic              multistep_active,
  input wire logic [RUN_W-1:0]  keypad_run,
  input wire logic [RUN_W-1:0]  terminal_run,
  input wire logic [FREQ_W-1:0] port1_freq,
  input wire logic [RUN_W-1:0]  port1_run,
  input wire logic [FREQ_W-1:0] port2_freq,
  input wire logic [FREQ_W-1:0] fieldbus_freq,
  input wire logic [RUN_W-1:0]  port2_run,
  input wire logic [RUN_W-1:0]  fieldbus_run,
  input wire logic [FREQ_W-1:0] freq_command,
  input wire logic [RUN_W-1:0]  run_command,
  input wire logic [1:0]        freq_source,
  input wire logic [1:0]        run_source
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_freq_port1: assert property (
    $past(aresetn) && freq_source == SRC_PORT1 |->
      freq_command == $past(port1_freq)) else $error("freq port1");
  a_freq_port2: assert property (
    $past(aresetn) && freq_source == SRC_PORT2 |->
      freq_command == $past(port2_freq)) else $error("freq port2");
  a_freq_bus: assert property (
    $past(aresetn) && freq_source == SRC_FIELDBUS |->
      freq_command == $past(fieldbus_freq)) else $error("freq bus");
  a_freq_local: assert property (
    $past(aresetn) && freq_source == SRC_LOCAL |->
      freq_command == ($past(multistep_active) ? $past(freq_multistep)
      : $past(freq_selected_setting))) else $error("freq local");
  a_run_port1: assert property (
    $past(aresetn) && run_source == SRC_PORT1 |->
      run_command == $past(port1_run)) else $error("run port1");
  a_run_port2: assert property (
    $past(aresetn) && run_source == SRC_PORT2 |->
      run_command == $past(port2_run)) else $error("run port2");
  a_run_bus: assert property (
    $past(aresetn) && run_source == SRC_FIELDBUS |->
      run_command == $past(fieldbus_run)) else $error("run bus");
  a_run_local: assert property (
    $past(aresetn) && run_source == SRC_LOCAL |->
      run_command == $past(keypad_run) ||
      run_command == $past(terminal_run, 3)) else $error("run local");
  a_bresp_once: assert property (
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("bvalid");
  a_rresp_once: assert property (
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid) else $error("rvalid");
  c_bus: cover property (freq_source == SRC_FIELDBUS);
  c_port2: cover property (run_source == SRC_PORT2);
  c_read: cover property (s_axi_rvalid && s_axi_rready);
endmodule : cmd_src_checker

// file: tb/remote_station.sv
// partner: words sent by the remote station on both links and fieldbus
`timescale 1ns/10ps
module remote_station
  import cmd_src_pkg::*;
(
  output logic [15:0]      port1_freq,
  output logic [RUN_W-1:0] port1_run,
  output logic [15:0]      port2_freq,
  output logic [RUN_W-1:0] port2_run,
  output logic [15:0]      fieldbus_freq,
  output logic [RUN_W-1:0] fieldbus_run
);
  // each source carries its own word so a wrong pick shows
  assign port1_freq    = 16'h3333;
  assign port1_run     = 9'h011;
  assign port2_freq    = 16'h4444;
  assign port2_run     = 9'h122;
  assign fieldbus_freq = 16'h5555;
  assign fieldbus_run  = 9'h0C4;
endmodule : remote_station

// file: tb/tb_top.sv
// testbench: register accesses and source selection checks
`timescale 1ns/10ps
module tb_top
  import cmd_src_pkg::*;
();
  logic              aclk = 1'b0, aresetn = 1'b0, tsel = 1'b0;
  logic [3:0]        s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0;
  logic [3:0]        s_axi_wstrb = 4'hF;
  logic              s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic              s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  logic              s_axi_rready = 1'b0, s_axi_awready, s_axi_wready;
  logic              s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [31:0]       s_axi_wdata = 32'h0, s_axi_rdata, d;
  logic [1:0]        s_axi_bresp, s_axi_rresp, freq_source, run_source, r;
  logic              remote_cmd_permit = 1'b0, multistep_active = 1'b0;
  logic [15:0]       freq_selected_setting = 16'h1111;
  logic [15:0]       freq_multistep = 16'h2222, freq_command;
  logic [15:0]       port1_freq, port2_freq, fieldbus_freq;
  logic [RUN_W-1:0]  keypad_run = 9'h0A5, terminal_run = 9'h15A;
  logic [RUN_W-1:0]  port1_run, port2_run, fieldbus_run, run_command;
  int                n_mismatch = 0, comparisons = 0;
  localparam logic [17:0] FT = 18'h24A44;
  localparam logic [17:0] RT = 18'h2A450;
  command_source_selector i_command_source_selector (.*);
  remote_station i_remote_station (.*);
  initial forever #25 aclk = ~aclk;
  function automatic logic [15:0] fw(input logic [1:0] s);
    return s == 2'h0 ? (multistep_active ? freq_multistep
      : freq_selected_setting) : s == 2'h1 ? port1_freq
      : s == 2'h2 ? port2_freq : fieldbus_freq;
  endfunction : fw
  function automatic logic [RUN_W-1:0] rw(input logic [1:0] s);
    return s == 2'h0 ? (tsel ? terminal_run : keypad_run)
      : s == 2'h1 ? port1_run : s == 2'h2 ? port2_run : fieldbus_run;
  endfunction : rw
  task automatic chk(input string nm, input logic [31:0] e, g);
    comparisons++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd
  task automatic src(input logic [1:0] ef, er);
    repeat (5) @(posedge aclk);
    chk("freq_source", 32'(ef), 32'(freq_source));
    chk("run_source", 32'(er), 32'(run_source));
    chk("freq_command", 32'(fw(ef)), 32'(freq_command));
    chk("run_command", 32'(rw(er)), 32'(run_command));
  endtask : src
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : close_out
  // ************************************************************
  // tests
  // ************************************************************
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    rd(ADDR_MODE);
    chk("mode reset", 32'h0, d);
    rd(ADDR_STATUS);
    chk("status reset", 32'h0, d);
    $display("test reset done");
    for (int c = 0; c < 9; c++) begin
      wr(ADDR_MODE, 32'(c));
      src(FT[2*c+:2], RT[2*c+:2]);
    end
    $display("test serial modes done");
    for (int b = 1; b < 4; b++) begin
      wr(ADDR_MODE, 32'h5 | (32'(b) << BUS_LSB));
      src(b[0] ? 2'h3 : 2'h2, b[1] ? 2'h3 : 2'h1);
    end
    $display("test fieldbus modes done");
    wr(ADDR_MODE, 32'h0001_0003);
    src(2'h0, 2'h0);
    remote_cmd_permit <= 1'b1;
    src(2'h1, 2'h1);
    $display("test permit done");
    tsel = 1'b1;
    multistep_active <= 1'b1;
    wr(ADDR_MODE, 32'h0100_0000);
    src(2'h0, 2'h0);
    rd(ADDR_MODE);
    chk("mode", 32'h0100_0000, d);
    rd(ADDR_STATUS);
    chk("status", 32'h0000_0100, d);
    $display("test local done");
    tsel = 1'b0;
    wr(ADDR_REMOTE, 32'h0000_01FF);
    chk("bresp ok", 32'(RESP_OKAY), 32'(r));
    rd(ADDR_REMOTE);
    chk("rresp ok", 32'(RESP_OKAY), 32'(r));
    chk("remote", 32'h0000_01FF, d);
    s_axi_wstrb <= 4'h2;
    wr(ADDR_REMOTE, 32'h0);
    s_axi_wstrb <= 4'hF;
    rd(ADDR_REMOTE);
    chk("remote lane", 32'h0000_00FF, d);
    wr(ADDR_MODE, 32'h9);
    src(2'h0, 2'h0);
    rd(ADDR_MODE);
    chk("mode code 9", 32'h9, d);
    $display("test remote done");
    rd(4'hC);
    chk("rresp", 32'(RESP_SLVERR), 32'(r));
    chk("rdata", 32'h0, d);
    wr(ADDR_STATUS, 32'h0000_FFFF);
    chk("bresp", 32'(RESP_SLVERR), 32'(r));
    $display("test errors done");
    close_out();
  end
  initial begin
    repeat (5000) @(posedge aclk);
    n_mismatch++;
    close_out();
  end
endmodule : tb_top
bind command_source_selector cmd_src_checker #(.FREQ_W(FREQ_W))
  i_cmd_src_checker (.*);
